// File: rank_pwr_ctrl.sv
// Per-rank DDR power-state controller with its register port.
`timescale 1ns/1ps
module rank_pwr_ctrl
  import rank_pwr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DATA_W-1:0] reg_rdata,
  input wire pkg_cstate_e pkg_cstate,
  input wire sleep_e sleep_state,
  input wire logic igfx_in_use,
  input wire logic gfx_idle,
  input wire logic disp_pending,
  input wire logic req_outstanding,
  input wire logic [NRANK-1:0] req_arrive,
  input wire logic [NRANK-1:0] banks_closed,
  input wire logic refresh_req,
  input wire logic refresh_done,
  output logic [NRANK-1:0] rank_cke,
  output logic [NRANK-1:0] rank_clk_en,
  output logic [NRANK-1:0] rank_odt_en,
  output logic [NRANK-1:0] rank_cs_en,
  output logic [NRANK-1:0] rank_io_off,
  output logic [NRANK-1:0] precharge_req,
  output logic [NRANK-1:0] rank_ready,
  output logic refresh_go,
  output logic ddr_io_supply_gate,
  output logic io_logic_supply_gate,
  output logic mem_power_off,
  output logic train_restore
);
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [PDTYPE_W-1:0] pd_type;
    logic [THRESH_W-1:0] thresh;
    logic cke_en;
    logic [NRANK-1:0] unpop;
    rank_st_e [NRANK-1:0] st;
    logic [NRANK-1:0][TXP_W-1:0] xcnt;
    logic [NRANK-1:0] woke;
    logic ref_busy;
    logic ref_go;
    logic [NRANK-1:0] cke;
    logic [NRANK-1:0] gate_on;
    logic [NRANK-1:0] io_off;
    logic [NRANK-1:0] pre;
    logic [NRANK-1:0] ready;
    logic ddr_gate;
    logic logic_gate;
    logic pwr_off;
    logic restore;
    logic low_prev;
  } state_s;

  state_s q;
  state_s n;
  logic [NRANK-1:0] expired;
  logic deep;
  logic sr_target;
  logic pd_on;
  logic closed_type;
  logic low_pwr;
  logic ref_blocked;
  logic ref_start;
  logic ref_end;
  logic [NRANK-1:0] pop_n;
  logic [NRANK-1:0] in_sr;

  // One idle timer per rank, all sharing the programmed threshold.
  genvar g;
  generate
    for (g = 0; g < NRANK; g++)
    begin : g_idle
      rank_idle_timer #(
        .W(THRESH_W)
      ) u_idle (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .arrive(req_arrive[g]),
        .thresh(q.thresh),
        .expired(expired[g])
      );
    end
  endgenerate

  // Policy terms, decoded from the power manager inputs, the power-down type register, the rank states and the refresh handshake.
  always_comb
  begin
    deep = (pkg_cstate >= PC3);
    if (sleep_state == SL_S3)
      sr_target = 1'b1;
    else if (sleep_state == SL_S0 && deep)
      sr_target = igfx_in_use ? (gfx_idle && !disp_pending) : !req_outstanding;
    else
      sr_target = 1'b0;
    pd_on = (q.pd_type != PDTYPE_NONE);
    closed_type = (q.pd_type == PDTYPE_CLOSED) || (q.pd_type == PDTYPE_DLL_OFF);
    low_pwr = deep || (sleep_state == SL_S3);
    ref_blocked = 1'b0;
    for (int r = 0; r < NRANK; r++)
    begin
      in_sr[r] = (q.st[r] == R_SR);
      if (q.st[r] == R_PD || q.st[r] == R_EXIT || q.st[r] == R_CLOSE || q.st[r] == R_SR)
        ref_blocked = 1'b1;
    end
    // Refresh is ignored while heading for self-refresh; the DRAM refreshes itself.
    ref_start = refresh_req && !q.ref_busy && !sr_target;
    ref_end = q.ref_busy && refresh_done;
  end

  // Next-state logic: register writes, refresh handshake and the per-rank machines.
  always_comb
  begin
    n = q;
    n.rdata = '0;
    if (reg_we && reg_addr == REG_PDCFG)
    begin
      n.pd_type = reg_wdata[PDTYPE_LSB +: PDTYPE_W];
      n.thresh = reg_wdata[THRESH_LSB +: THRESH_W];
    end
    if (reg_we && reg_addr == REG_CTRL)
    begin
      n.cke_en = reg_wdata[CTRL_CKE_EN_BIT];
      n.unpop = ~reg_wdata[CTRL_POP_LSB +: NRANK];
    end
    if (reg_re)
    begin
      unique case (reg_addr)
        REG_PDCFG:
        begin
          n.rdata[PDTYPE_LSB +: PDTYPE_W] = q.pd_type;
          n.rdata[THRESH_LSB +: THRESH_W] = q.thresh;
        end
        REG_CTRL:
        begin
          n.rdata[CTRL_CKE_EN_BIT] = q.cke_en;
          n.rdata[CTRL_POP_LSB +: NRANK] = ~q.unpop;
        end
        REG_STATUS:
        begin
          n.rdata[ST_CKE_LSB +: NRANK] = q.cke;
          n.rdata[ST_SR_LSB +: NRANK] = in_sr;
          n.rdata[ST_READY_LSB +: NRANK] = q.ready;
          n.rdata[ST_REF_BIT] = q.ref_busy;
          n.rdata[ST_OFF_BIT] = q.pwr_off;
        end
        default: n.rdata = '0;
      endcase
    end
    n.pwr_off = (sleep_state == SL_S4);
    pop_n = ~n.unpop;

    if (ref_start)
    begin
      n.ref_busy = 1'b1;
      for (int r = 0; r < NRANK; r++)
        n.woke[r] = (q.st[r] == R_PD);
    end
    n.ref_go = q.ref_busy && !ref_blocked && !ref_end;
    if (ref_end)
      n.ref_busy = 1'b0;

    for (int r = 0; r < NRANK; r++)
    begin
      unique case (q.st[r])
        R_OFF:
        begin
          n.st[r] = R_EXIT;
          n.xcnt[r] = '0;
        end
        R_ACT:
        begin
          if (ref_end && q.woke[r] && !req_arrive[r])
            n.st[r] = closed_type ? R_CLOSE : R_PD;
          else if (sr_target && !q.ref_busy)
            n.st[r] = R_CLOSE;
          else if (pd_on && expired[r] && !req_arrive[r] && !q.ref_busy)
            n.st[r] = closed_type ? R_CLOSE : R_PD;
        end
        R_CLOSE:
        begin
          if (req_arrive[r] || q.ref_busy)
            n.st[r] = R_ACT;
          else if (banks_closed[r])
            n.st[r] = sr_target ? R_SR : (pd_on ? R_PD : R_ACT);
        end
        R_PD:
        begin
          if (req_arrive[r] || ref_start || !pd_on || sr_target)
          begin
            n.st[r] = R_EXIT;
            n.xcnt[r] = '0;
          end
        end
        R_EXIT:
        begin
          // hold off commands for exit time
          if (q.xcnt[r] == TXP_CYC - TXP_W'(1))
            n.st[r] = R_ACT;
          else
            n.xcnt[r] = q.xcnt[r] + TXP_W'(1);
        end
        R_SR:
        begin
          if (!sr_target)
          begin
            n.st[r] = R_EXIT;
            n.xcnt[r] = '0;
          end
        end
        // An unused state code falls back to off, then restarts cleanly.
        default: n.st[r] = R_OFF;
      endcase
      // disabled, absent or unpowered ranks stay off
      if (!n.cke_en || !pop_n[r] || n.pwr_off)
        n.st[r] = R_OFF;
      if (ref_end)
        n.woke[r] = 1'b0;
      // per-rank gating of clock, CKE, ODT, CS
      n.cke[r] = (n.st[r] == R_ACT) || (n.st[r] == R_CLOSE) || (n.st[r] == R_EXIT);
      n.gate_on[r] = (n.st[r] != R_OFF) && (n.st[r] != R_SR);
      n.io_off[r] = !pop_n[r];
      n.pre[r] = (n.st[r] == R_CLOSE);
      n.ready[r] = (n.st[r] == R_ACT);
    end

    // deep idle gates DDR I/O supply
    n.ddr_gate = low_pwr;
    n.logic_gate = (pkg_cstate >= PC7);
    n.low_prev = low_pwr;
    n.restore = q.low_prev && !low_pwr;
  end

  // All state in one register; reset leaves every CKE low and ranks off.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else if (ce)
      q <= n;
  end

  // Outputs come straight from the state register.
  assign reg_rdata = q.rdata;
  assign rank_cke = q.cke;
  assign rank_clk_en = q.gate_on;
  assign rank_odt_en = q.gate_on;
  assign rank_cs_en = q.gate_on;
  assign rank_io_off = q.io_off;
  assign precharge_req = q.pre;
  assign rank_ready = q.ready;
  assign refresh_go = q.ref_go;
  assign ddr_io_supply_gate = q.ddr_gate;
  assign io_logic_supply_gate = q.logic_gate;
  assign mem_power_off = q.pwr_off;
  assign train_restore = q.restore;

  property p_cke_needs_enable;
    @(posedge ref_clk) disable iff (!rst_b)
    !q.cke_en |-> (rank_cke == '0);
  endproperty
  a_cke_needs_enable: assert property (p_cke_needs_enable)
    else $error("CKE high while firmware enable is clear.");

  property p_unused_gated;
    @(posedge ref_clk) disable iff (!rst_b)
    ((rank_clk_en | rank_cke) & q.unpop) == '0;
  endproperty
  a_unused_gated: assert property (p_unused_gated)
    else $error("Unused rank has clock or CKE enabled.");

  property p_unused_io_off;
    @(posedge ref_clk) disable iff (!rst_b)
    rank_io_off == q.unpop;
  endproperty
  a_unused_io_off: assert property (p_unused_io_off)
    else $error("I/O disable does not follow population.");

  property p_exit_wait;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(rank_ready[0]) |-> $past(rank_cke[0], TXP_CYC_I);
  endproperty
  a_exit_wait: assert property (p_exit_wait)
    else $error("Rank ready before exit time elapsed.");

  property p_closed_before_cke_drop;
    @(posedge ref_clk) disable iff (!rst_b)
    ($fell(rank_cke[0]) && q.cke_en && !q.unpop[0] && !q.pwr_off
      && $past(precharge_req[0])) |-> $past(banks_closed[0]);
  endproperty
  a_closed_before_cke_drop: assert property (p_closed_before_cke_drop)
    else $error("CKE dropped before banks were closed.");

  property p_open_no_precharge;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(precharge_req[0]) |-> $past(closed_type || sr_target);
  endproperty
  a_open_no_precharge: assert property (p_open_no_precharge)
    else $error("Pages closed under open-page power-down.");

  property p_refresh_all_awake;
    @(posedge ref_clk) disable iff (!rst_b)
    refresh_go |-> (((~rank_cke) & (~q.unpop)) == '0 || !q.cke_en || q.pwr_off);
  endproperty
  a_refresh_all_awake: assert property (p_refresh_all_awake)
    else $error("Refresh issued while a rank is powered down.");

  property p_hibernate_off;
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && sleep_state == SL_S4) |=> (mem_power_off && rank_cke == '0);
  endproperty
  a_hibernate_off: assert property (p_hibernate_off)
    else $error("Memory not powered off in hibernate.");

  property p_logic_gate_deepest;
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && pkg_cstate >= PC7) |=> (io_logic_supply_gate && ddr_io_supply_gate);
  endproperty
  a_logic_gate_deepest: assert property (p_logic_gate_deepest)
    else $error("Deepest idle without both supply gates.");

  property p_restore_pulse;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(train_restore) |-> $past(ddr_io_supply_gate) ##1 (!train_restore || !$past(ce));
  endproperty
  a_restore_pulse: assert property (p_restore_pulse)
    else $error("Training restore not a single pulse on resume.");

endmodule // rank_pwr_ctrl

// File: rank_pwr_pkg.sv
// Constants, encodings and register map for the rank power-state controller.
package rank_pwr_pkg;
  localparam int NRANK = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_PDCFG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam int PDTYPE_LSB = 12;
  localparam int PDTYPE_W = 4;
  localparam int THRESH_LSB = 0;
  localparam int THRESH_W = 12;
  localparam int CTRL_CKE_EN_BIT = 0;
  localparam int CTRL_POP_LSB = 4;
  localparam int ST_CKE_LSB = 0;
  localparam int ST_SR_LSB = 4;
  localparam int ST_READY_LSB = 8;
  localparam int ST_REF_BIT = 12;
  localparam int ST_OFF_BIT = 13;
  localparam logic [PDTYPE_W-1:0] PDTYPE_NONE = 4'h0;
  localparam logic [PDTYPE_W-1:0] PDTYPE_OPEN = 4'h1;
  localparam logic [PDTYPE_W-1:0] PDTYPE_CLOSED = 4'h2;
  localparam logic [PDTYPE_W-1:0] PDTYPE_DLL_OFF = 4'h3;
  localparam logic [PDTYPE_W-1:0] RST_PDTYPE = 4'h0;
  localparam logic [THRESH_W-1:0] RST_THRESH = 12'h000;
  localparam int TXP_NS = 24;
  localparam int CLK_MHZ = 100;
  localparam int TXP_CYC_I = (TXP_NS * CLK_MHZ + 999) / 1000;
  localparam int TXP_W = 4;
  localparam logic [TXP_W-1:0] TXP_CYC = TXP_W'(TXP_CYC_I);
  typedef enum logic [2:0] {PC0, PC1, PC1E, PC3, PC6, PC7} pkg_cstate_e;
  typedef enum logic [1:0] {SL_S0, SL_S3, SL_S4} sleep_e;
  typedef enum logic [2:0] {R_OFF, R_ACT, R_CLOSE, R_PD, R_EXIT, R_SR} rank_st_e;
endpackage

// File: rank_idle_timer.sv
// Idle counter for one rank; flags expiry after a set number of idle cycles.
`timescale 1ns/1ps
module rank_idle_timer
  import rank_pwr_pkg::*;
#(
  parameter int W = THRESH_W
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic arrive,
  input wire logic [W-1:0] thresh,
  output logic expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic exp;
  } tmr_s;

  tmr_s q;
  tmr_s n;

  // Count saturates so a long idle stretch never wraps back to busy.
  always_comb
  begin
    n = q;
    if (arrive)
    begin
      n.cnt = '0;
      n.exp = 1'b0;
    end
    else
    begin
      if (q.cnt != {W{1'b1}})
        n.cnt = q.cnt + W'(1);
      n.exp = (q.cnt >= thresh);
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else if (ce)
      q <= n;
  end

  assign expired = q.exp;

  property p_arrive_clears;
    @(posedge ref_clk) disable iff (!rst_b)
    (arrive && ce) |=> (!expired && q.cnt == '0);
  endproperty
  a_arrive_clears: assert property (p_arrive_clears)
    else $error("Idle timer not restarted by arrival.");

endmodule // rank_idle_timer

// File: dram_rank_model.sv
// Behavioural DRAM ranks: tracks open pages per rank and answers precharge requests.
`timescale 1ns/1ps
module dram_rank_model
  import rank_pwr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic [NRANK-1:0] req_arrive,
  input wire logic [NRANK-1:0] precharge_req,
  output logic [NRANK-1:0] banks_closed
);
  logic [2:0] busy_q [NRANK];

  // A transaction leaves a page open; a precharge takes one cycle, or four when slow.
  // Power-up leaves every bank precharged, so ranks start closed.
  // close on request
  always @(posedge ref_clk or negedge rst_b)
  begin
    for (int r = 0; r < NRANK; r++)
    begin
      if (!rst_b)
      begin
        banks_closed[r] <= 1'h1;
        busy_q[r] <= 3'h0;
      end
      else if (req_arrive[r])
      begin
        banks_closed[r] <= 1'h0;
        busy_q[r] <= 3'h0;
      end
      else if (precharge_req[r] && !banks_closed[r])
      begin
        busy_q[r] <= busy_q[r] + 3'h1;
        banks_closed[r] <= (busy_q[r] >= (slow ? 3'h3 : 3'h0));
      end
    end
  end
endmodule // dram_rank_model

// File: rank_pwr_ctrl_tb_top.sv
// Self-checking bench for the rank power-state controller.
`timescale 1ns/1ps
module rank_pwr_ctrl_tb_top
  import rank_pwr_pkg::*;
;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic ce = 1'h1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_we = 1'h0;
  logic reg_re = 1'h0;
  logic [DATA_W-1:0] reg_rdata;
  pkg_cstate_e pkg_cstate = PC0;
  sleep_e sleep_state = SL_S0;
  logic igfx_in_use = 1'h1;
  logic gfx_idle = 1'h1;
  logic disp_pending = 1'h0;
  logic req_outstanding = 1'h0;
  logic [NRANK-1:0] req_arrive = '0;
  logic refresh_req = 1'h0;
  logic refresh_done = 1'h0;
  logic slow = 1'h0;
  logic [NRANK-1:0] banks_closed, rank_cke, rank_clk_en, rank_odt_en, rank_cs_en;
  logic [NRANK-1:0] rank_io_off, precharge_req, rank_ready;
  logic refresh_go, ddr_io_supply_gate, io_logic_supply_gate, mem_power_off, train_restore;
  int err_total = 0;
  int comparisons = 0;
  int tr_cnt = 0;
  int open_cnt = 0;
  pkg_cstate_e cp[5] = '{PC1E, PC3, PC6, PC7, PC3};
  logic [3:0] cb[5] = '{4'hc, 4'hc, 4'he, 4'h0, 4'h1};

  rank_pwr_ctrl DUT (.ref_clk, .rst_b, .ce, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .pkg_cstate, .sleep_state, .igfx_in_use, .gfx_idle, .disp_pending,
    .req_outstanding, .req_arrive, .banks_closed, .refresh_req, .refresh_done, .rank_cke,
    .rank_clk_en, .rank_odt_en, .rank_cs_en, .rank_io_off, .precharge_req, .rank_ready,
    .refresh_go, .ddr_io_supply_gate, .io_logic_supply_gate, .mem_power_off, .train_restore);

  dram_rank_model ranks (.ref_clk, .rst_b, .slow, .req_arrive, .precharge_req,
    .banks_closed);

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  // Count restore pulses and cycles where a populated rank sleeps with pages open.
  always @(posedge ref_clk)
  begin
    tr_cnt <= tr_cnt + int'(train_restore);
    open_cnt <= open_cnt + int'(|(~rank_cke & ~banks_closed & ~rank_io_off));
  end

  // Self-refresh is expected only in deep idle with the quiet condition of the graphics mode.
  function automatic logic exp_sr(input pkg_cstate_e p, input logic [3:0] b);
    return (p >= PC3) && (b[3] ? (b[2] && !b[1]) : !b[0]);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Sample one nanosecond after the edge so the design's updates have landed.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_we <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'h0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string w);
    @(posedge ref_clk);
    reg_re <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'h0;
    #1;
    chk(w, e, reg_rdata);
  endtask

  task automatic arrive(input logic [NRANK-1:0] m);
    @(posedge ref_clk);
    req_arrive <= m;
    @(posedge ref_clk);
    req_arrive <= '0;
    #1;
  endtask

  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // The tests need about 900 cycles; a hang is cut off far beyond that.
  initial
  begin
    #100us;
    err_total++;
    stop_test();
  end

  // Main sequence: registers, idle power-down, wake, refresh, idle states, sleep, population.
  initial
  begin
    logic [11:0] thr;
    logic [3:0] b;
    pkg_cstate_e p;
    int r;
    int base;
    r = $urandom(32'h8324);
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'h1;
    tick(8);
    chk("cke_held", 32'h0, 32'(rank_cke));
    rd(REG_PDCFG, 32'h0, "pdcfg_rst");
    rd(REG_CTRL, 32'hf0, "ctrl_rst");
    rd(8'h3c, 32'h0, "unmapped");
    wr(REG_STATUS, 32'hffff);
    rd(REG_STATUS, 32'h0, "status_ro");
    $display("Test registers done");
    thr = 12'(4 + $urandom % 12);
    wr(REG_PDCFG, {16'h0, PDTYPE_OPEN, thr});
    rd(REG_PDCFG, {16'h0, PDTYPE_OPEN, thr}, "pdcfg_rw");
    wr(REG_CTRL, 32'hf1);
    arrive(4'hf);
    base = open_cnt;
    tick(int'(thr) - 1);
    chk("cke_busy", 32'hf, 32'(rank_cke));
    tick(12);
    chk("cke_open_pd", 32'h0, 32'(rank_cke));
    chk("pages_kept", 32'h1, 32'(open_cnt > base));
    r = $urandom % NRANK;
    arrive(4'(1 << r));
    chk("wake_cke", 32'h1, 32'(rank_cke[r]));
    tick(2);
    chk("wake_wait", 32'h0, 32'(rank_ready[r]));
    tick(1);
    chk("wake_ready", 32'h1, 32'(rank_ready[r]));
    $display("Test open page done");
    slow <= 1'h1;
    wr(REG_PDCFG, {16'h0, PDTYPE_CLOSED, thr});
    arrive(4'hf);
    base = open_cnt;
    tick(int'(thr) + 20);
    chk("cke_closed_pd", 32'h0, 32'(rank_cke));
    chk("closed_first", 32'(base), 32'(open_cnt));
    @(posedge ref_clk);
    refresh_req <= 1'h1;
    @(posedge ref_clk);
    refresh_req <= 1'h0;
    repeat (40) if (refresh_go !== 1'h1) tick(1);
    chk("ref_go", 32'h1, 32'(refresh_go));
    chk("ref_awake", 32'hf, 32'(rank_cke));
    @(posedge ref_clk);
    refresh_done <= 1'h1;
    @(posedge ref_clk);
    refresh_done <= 1'h0;
    tick(20);
    chk("ref_repd", 32'h0, 32'(rank_cke));
    $display("Test closed page and refresh done");
    // Fixed corners first, then random idle-state mixes.
    for (int n = 0; n < 10; n++)
    begin
      p = (n < 5) ? cp[n] : pkg_cstate_e'(3'($urandom % 6));
      b = (n < 5) ? cb[n] : 4'($urandom);
      @(posedge ref_clk);
      pkg_cstate <= p;
      {igfx_in_use, gfx_idle, disp_pending, req_outstanding} <= b;
      tick(30);
      chk("sr_clk", exp_sr(p, b) ? 32'h0 : 32'hf, 32'(rank_clk_en));
      chk("ddr_gate", 32'(p >= PC3), 32'(ddr_io_supply_gate));
      chk("logic_gate", 32'(p == PC7), 32'(io_logic_supply_gate));
      base = tr_cnt;
      @(posedge ref_clk);
      pkg_cstate <= PC0;
      tick(30);
      chk("restore", 32'(p >= PC3), 32'(tr_cnt - base));
    end
    $display("Test idle states done");
    @(posedge ref_clk);
    sleep_state <= SL_S3;
    tick(30);
    chk("s3_sr", 32'h0, 32'({rank_clk_en, rank_cke}));
    // Every populated rank shows up in the self-refresh status field.
    rd(REG_STATUS, 32'(4'hf) << ST_SR_LSB, "status_sr");
    base = tr_cnt;
    @(posedge ref_clk);
    sleep_state <= SL_S4;
    tick(5);
    chk("s4_off", 32'h1, 32'(mem_power_off));
    chk("s4_cke", 32'h0, 32'(rank_cke));
    chk("s3_restore", 32'h1, 32'(tr_cnt - base));
    @(posedge ref_clk);
    sleep_state <= SL_S0;
    tick(30);
    $display("Test sleep done");
    wr(REG_CTRL, 32'h31);
    tick(4);
    chk("io_off", 32'hc, 32'(rank_io_off));
    chk("gates", 32'h333, 32'({rank_clk_en, rank_odt_en, rank_cs_en}));
    chk("cke_unused", 32'h0, 32'(rank_cke & 4'hc));
    $display("Test population done");
    // No power-down wakes the sleeping ranks; the DLL-off type closes pages first.
    wr(REG_PDCFG, {16'h0, PDTYPE_NONE, thr});
    tick(10);
    chk("cke_no_pd", 32'h3, 32'(rank_cke));
    wr(REG_PDCFG, {16'h0, PDTYPE_DLL_OFF, thr});
    tick(10);
    chk("cke_dll_off", 32'h0, 32'(rank_cke));
    $display("Test power-down types done");
    // With the clock enable low, a write and an arrival must both be ignored.
    @(posedge ref_clk);
    ce <= 1'h0;
    wr(REG_CTRL, 32'hf1);
    arrive(4'h1);
    tick(3);
    chk("ce_frozen", 32'h0c, 32'({rank_cke, rank_io_off}));
    @(posedge ref_clk);
    ce <= 1'h1;
    rd(REG_CTRL, 32'h31, "ce_ctrl");
    $display("Test clock enable done");
    stop_test();
  end
endmodule // rank_pwr_ctrl_tb_top
